//--- logic/atpf_host.sv
/*
  Host-side framer for asynchronous block transmit packets. Takes one
  request struct and payload quadlets, writes four header quadlets and
  the payload into the link's transmit queue.
  Assumes the transmit queue accepts a word when tq_valid and tq_ready.
*/
// Functional notes
// - Response code 4: responder resource conflict; request may be retried.
// - Response code 5: hardware error at responder, data not available.
// - Response code 6: request header field unsupported or invalid.
// - Response code 7: address not accessible; codes 8 to 15 never sent.
// - Target offset is quadlet aligned, a multiple of four.
// - Read requests carry no data word; only write requests and read responses carry data.
// - Quadlet one carries speed, tag, retry, transaction code, priority.
// - Request quadlets two and three hold node id and 48-bit offset.
// - Quadlet four upper half holds the payload byte count.
// - Quadlet four lower half holds the extended transaction code.
// - Response quadlet two upper half holds the requesting node id.
// - Response quadlet two carries the response code.
// - Response quadlet three is reserved and sent as zero.
// - Speed 00/01/10 mean 100/200/400 Mbit/s; 11 is undefined.
// - Response code 0 means complete; codes 1 to 3 reserved.
// - Retry code 00 new, 01 retry_X, 10 retryA, 11 retryB.
// - Node id is 10-bit bus number followed by 6-bit node number.
`timescale 1ns/1ps
`include "atpf_consts.svh"

module atpf_host import atpf_pkg::*; #(
  parameter int DEPTH = `ATPF_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire atpf_req_s   cmd_req,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  output logic             cmd_err,
  input  wire logic [31:0] pay_data,
  input  wire logic        pay_valid,
  output logic             pay_ready,
  output logic [31:0]      tq_data,
  output logic             tq_valid,
  output logic             tq_last,
  input  wire logic        tq_ready
);

  // ****************************************************************
  // Payload FIFO
  // ****************************************************************
  logic [31:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;

  atpf_fifo #(
    .WIDTH (`ATPF_WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (pay_data),
    .in_valid  (pay_valid),
    .in_ready  (pay_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ****************************************************************
  // Request check and header words
  // ****************************************************************
  atpf_state_e state_reg, state_next;
  atpf_req_s   cur_reg, cur_next;
  logic [1:0]  idx_reg, idx_next;
  logic [14:0] left_reg, left_next;
  logic [2:0]  sel_reg, sel_next;
  logic [31:0] data_next;
  logic        valid_next, last_next, err_next, ready_next;
  logic        req_ok, adv;
  logic [16:0] byte_sum;
  logic [14:0] quads;
  logic [31:0] hdr_word;

  always_comb begin
    req_ok = (cmd_req.spd != `ATPF_SPD_UNDEF);
    if (atpf_is_resp(cmd_req.kind)) begin
      req_ok = req_ok && atpf_response_code_ok(cmd_req.response_code);
    end else begin
      req_ok = req_ok && (cmd_req.offset_low[1:0] == 2'h0);
    end
    byte_sum = {1'b0, cmd_req.payload_byte_count} + 17'h00003;
    quads    = atpf_has_pay(cmd_req.kind) ? byte_sum[16:2] : 15'h0000;
  end

  always_comb begin
    hdr_word = `ATPF_RST_WORD;
    case (idx_reg)
      2'h0: begin
        hdr_word[`ATPF_Q1_SPD_LSB +: 2]   = cur_reg.spd;
        hdr_word[`ATPF_Q1_TAG_LSB +: 6]   = cur_reg.tag;
        hdr_word[`ATPF_Q1_RETRY_LSB +: 2] = cur_reg.retry;
        hdr_word[`ATPF_Q1_TRANSACTION_CODE_LSB +: 4] = atpf_transaction_code(cur_reg.kind);
        hdr_word[`ATPF_Q1_PRIO_LSB +: 4]  = `ATPF_PRIO_CABLE;
      end
      2'h1: begin
        hdr_word[`ATPF_Q2_NODE_LSB +: 16] = cur_reg.node_id;
        if (atpf_is_resp(cur_reg.kind)) begin
          hdr_word[`ATPF_Q2_RESPONSE_CODE_LSB +: 4] = cur_reg.response_code;
        end else begin
          hdr_word[15:0] = cur_reg.offset_high;
        end
      end
      2'h2: begin
        if (!atpf_is_resp(cur_reg.kind)) begin
          hdr_word = cur_reg.offset_low;
        end
      end
      default: begin
        hdr_word[`ATPF_Q4_COUNT_LSB +: 16] = cur_reg.payload_byte_count;
        hdr_word[`ATPF_Q4_EXT_LSB +: 16]   =
          cur_reg.extended_transaction_code;
      end
    endcase
  end

  // ****************************************************************
  // Framing state machine
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    cur_next   = cur_reg;
    idx_next   = idx_reg;
    left_next  = left_reg;
    sel_next   = sel_reg;
    data_next  = tq_data;
    valid_next = tq_valid && !tq_ready;
    last_next  = tq_last;
    err_next   = 1'b0;
    fifo_pop   = 1'b0;
    adv        = !tq_valid || tq_ready;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          if (!req_ok) begin
            err_next = 1'b1;
          end else begin
            cur_next   = cmd_req;
            idx_next   = 2'h0;
            left_next  = quads;
            state_next = ST_HDR;
          end
        end
      end
      ST_HDR: begin
        if (adv) begin
          valid_next = 1'b1;
          data_next  = hdr_word;
          sel_next   = {1'b0, idx_reg};
          idx_next   = idx_reg + 2'h1;
          last_next  = (idx_reg == 2'h3) && (left_reg == 15'h0000);
          if (idx_reg == 2'h3) begin
            state_next = (left_reg == 15'h0000) ? ST_IDLE : ST_PAY;
          end
        end
      end
      ST_PAY: begin
        if (adv && fifo_valid) begin
          fifo_pop   = 1'b1;
          valid_next = 1'b1;
          data_next  = fifo_data;
          sel_next   = `ATPF_SEL_PAY;
          left_next  = left_reg - 15'h0001;
          last_next  = (left_reg == 15'h0001);
          if (left_reg == 15'h0001) begin
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // New request only once the last word has left
    ready_next = (state_next == ST_IDLE) && !valid_next;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cur_reg   <= '0;
      idx_reg   <= 2'h0;
      left_reg  <= 15'h0000;
      sel_reg   <= `ATPF_SEL_Q1;
      tq_data   <= `ATPF_RST_WORD;
      tq_valid  <= 1'b0;
      tq_last   <= 1'b0;
      cmd_err   <= 1'b0;
      cmd_ready <= 1'b1;
    end else begin
      state_reg <= state_next;
      cur_reg   <= cur_next;
      idx_reg   <= idx_next;
      left_reg  <= left_next;
      sel_reg   <= sel_next;
      tq_data   <= data_next;
      tq_valid  <= valid_next;
      tq_last   <= last_next;
      cmd_err   <= err_next;
      cmd_ready <= ready_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic out_q1, out_q2, out_q3, out_q4, is_resp;
  assign is_resp = atpf_is_resp(cur_reg.kind);
  assign out_q1  = tq_valid && (sel_reg == `ATPF_SEL_Q1);
  assign out_q2  = tq_valid && (sel_reg == `ATPF_SEL_Q2);
  assign out_q3  = tq_valid && (sel_reg == `ATPF_SEL_Q3);
  assign out_q4  = tq_valid && (sel_reg == `ATPF_SEL_Q4);

  a_response_code_legal: assert property (
    out_q2 && is_resp |->
      atpf_response_code_ok(tq_data[`ATPF_Q2_RESPONSE_CODE_LSB +: 4])
      && tq_data[`ATPF_Q2_RESPONSE_CODE_LSB +: 4] == cur_reg.response_code)
    else $error("illegal response code sent");

  a_spd_defined: assert property (
    out_q1 |-> tq_data[`ATPF_Q1_SPD_LSB +: 2] != `ATPF_SPD_UNDEF)
    else $error("undefined speed code sent");

  a_ctrl_quadlet: assert property (
    out_q1 |-> tq_data[`ATPF_Q1_TRANSACTION_CODE_LSB +: 4] == atpf_transaction_code(cur_reg.kind)
      && tq_data[`ATPF_Q1_RETRY_LSB +: 2] == cur_reg.retry
      && tq_data[`ATPF_Q1_TAG_LSB +: 6] == cur_reg.tag
      && tq_data[`ATPF_Q1_PRIO_LSB +: 4] == `ATPF_PRIO_CABLE)
    else $error("control quadlet wrong");

  a_addr_pair: assert property (
    out_q2 && !is_resp |->
      tq_data == {cur_reg.node_id.bus, cur_reg.node_id.node,
                  cur_reg.offset_high})
    else $error("address quadlet two wrong");

  a_offset_align: assert property (
    out_q3 && !is_resp |-> tq_data[1:0] == 2'h0
      && tq_data == cur_reg.offset_low)
    else $error("offset not quadlet aligned");

  a_resp_node: assert property (
    out_q2 && is_resp |->
      tq_data[`ATPF_Q2_NODE_LSB +: 16] == cur_reg.node_id)
    else $error("response node id wrong");

  a_resp_rsvd: assert property (
    out_q3 && is_resp |-> tq_data == `ATPF_RST_WORD)
    else $error("reserved quadlet not zero");

  a_count_ext: assert property (
    out_q4 |->
      tq_data[`ATPF_Q4_COUNT_LSB +: 16] == cur_reg.payload_byte_count
      && tq_data[`ATPF_Q4_EXT_LSB +: 16]
         == cur_reg.extended_transaction_code)
    else $error("quadlet four fields wrong");

  a_hdr_order: assert property (
    tq_valid && tq_ready && sel_reg < `ATPF_SEL_Q4 |=>
      tq_valid && sel_reg == $past(sel_reg) + 3'h1)
    else $error("header quadlets out of order");

  a_no_payload: assert property (
    out_q4 && !atpf_has_pay(cur_reg.kind) |-> tq_last)
    else $error("payload-free packet not ended");

  a_pay_follows: assert property (
    out_q4 && tq_ready && !tq_last |=> state_reg == ST_PAY
      && !tq_valid || sel_reg == `ATPF_SEL_PAY)
    else $error("payload not after quadlet four");

  a_bad_refused: assert property (
    cmd_valid && cmd_ready && cmd_req.spd == `ATPF_SPD_UNDEF |=>
      cmd_err && state_reg == ST_IDLE)
    else $error("bad request not refused");

  c_wr_req: cover property (out_q4 && cur_reg.kind == KIND_WR_REQ ##1
                            sel_reg == `ATPF_SEL_PAY);
  c_rd_req: cover property (out_q4 && tq_ready && cur_reg.kind == KIND_RD_REQ);
  c_rd_resp: cover property (tq_valid && tq_last && tq_ready
                             && cur_reg.kind == KIND_RD_RESP);
  c_refused: cover property (cmd_err);

endmodule

//--- logic/atpf_consts.svh
/*
  Constants of the asynchronous transmit packet framer: transaction and
  response codes, header field positions, reset values and sizes.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef ATPF_CONSTS_SVH
`define ATPF_CONSTS_SVH

// ****************************************************************
// Transaction codes of the four block packet types
// ****************************************************************
`define ATPF_TC_WR_REQ        4'h1
`define ATPF_TC_WR_RESP       4'h2
`define ATPF_TC_RD_REQ        4'h5
`define ATPF_TC_RD_RESP       4'h7

// ****************************************************************
// Response codes and speed codes
// ****************************************************************
`define ATPF_RC_COMPLETE      4'h0
`define ATPF_RC_CONFLICT      4'h4
`define ATPF_RC_DATA_ERR      4'h5
`define ATPF_RC_TYPE_ERR      4'h6
`define ATPF_RC_ADDR_ERR      4'h7
`define ATPF_SPD_100          2'h0
`define ATPF_SPD_200          2'h1
`define ATPF_SPD_400          2'h2
`define ATPF_SPD_UNDEF        2'h3
`define ATPF_PRIO_CABLE       4'h0

// ****************************************************************
// Header field positions (lsb of each field)
// ****************************************************************
`define ATPF_Q1_SPD_LSB       16
`define ATPF_Q1_TAG_LSB       10
`define ATPF_Q1_RETRY_LSB     8
`define ATPF_Q1_TRANSACTION_CODE_LSB     4
`define ATPF_Q1_PRIO_LSB      0
`define ATPF_Q2_NODE_LSB      16
`define ATPF_Q2_RESPONSE_CODE_LSB     12
`define ATPF_Q4_COUNT_LSB     16
`define ATPF_Q4_EXT_LSB       0

// ****************************************************************
// Word selectors, sizes and reset values
// ****************************************************************
`define ATPF_SEL_Q1           3'h0
`define ATPF_SEL_Q2           3'h1
`define ATPF_SEL_Q3           3'h2
`define ATPF_SEL_Q4           3'h3
`define ATPF_SEL_PAY          3'h4
`define ATPF_WORD_W           32
`define ATPF_FIFO_DEPTH       32
`define ATPF_RST_WORD         32'h0000_0000

`endif

//--- logic/atpf_pkg.sv
/*
  Types of the asynchronous transmit packet framer: packet kinds, states,
  the request struct and small field helpers.
  Assumes atpf_consts.svh is on the include path.
*/
`include "atpf_consts.svh"

package atpf_pkg;

  typedef enum logic [1:0] {
    KIND_WR_REQ  = 2'h0,
    KIND_WR_RESP = 2'h1,
    KIND_RD_REQ  = 2'h2,
    KIND_RD_RESP = 2'h3
  } atpf_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_HDR  = 3'h2,
    ST_PAY  = 3'h4
  } atpf_state_e;

  typedef struct packed {
    logic [9:0] bus;
    logic [5:0] node;
  } atpf_node_id_s;

  typedef struct packed {
    atpf_kind_e    kind;
    logic [1:0]    spd;
    logic [5:0]    tag;
    logic [1:0]    retry;
    atpf_node_id_s node_id;
    logic [15:0]   offset_high;
    logic [31:0]   offset_low;
    logic [3:0]    response_code;
    logic [15:0]   payload_byte_count;
    logic [15:0]   extended_transaction_code;
  } atpf_req_s;

  function automatic logic [3:0] atpf_transaction_code(input atpf_kind_e k);
    case (k)
      KIND_WR_REQ:  atpf_transaction_code = `ATPF_TC_WR_REQ;
      KIND_WR_RESP: atpf_transaction_code = `ATPF_TC_WR_RESP;
      KIND_RD_REQ:  atpf_transaction_code = `ATPF_TC_RD_REQ;
      default:      atpf_transaction_code = `ATPF_TC_RD_RESP;
    endcase
  endfunction

  function automatic logic atpf_is_resp(input atpf_kind_e k);
    atpf_is_resp = (k == KIND_WR_RESP) || (k == KIND_RD_RESP);
  endfunction

  function automatic logic atpf_has_pay(input atpf_kind_e k);
    atpf_has_pay = (k == KIND_WR_REQ) || (k == KIND_RD_RESP);
  endfunction

  function automatic logic atpf_response_code_ok(input logic [3:0] rc);
    atpf_response_code_ok = (rc == `ATPF_RC_COMPLETE) || (rc == `ATPF_RC_CONFLICT)
                 || (rc == `ATPF_RC_DATA_ERR) || (rc == `ATPF_RC_TYPE_ERR)
                 || (rc == `ATPF_RC_ADDR_ERR);
  endfunction

endpackage

//--- logic/atpf_fifo.sv
/*
  Payload FIFO of the transmit packet framer, flip-flop storage.
  Assumes one clock; writes take in_valid and in_ready, reads take
  out_valid and out_ready; flags are registered.
*/
`timescale 1ns/1ps
`include "atpf_consts.svh"

module atpf_fifo import atpf_pkg::*; #(
  parameter int WIDTH = `ATPF_WORD_W,
  parameter int DEPTH = `ATPF_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             full_reg, full_next, empty_reg, empty_next;
  logic             room_reg, room_next;
  logic             push, pop;

  assign in_ready  = room_reg;
  assign out_valid = !empty_reg;
  assign out_data  = mem_reg[rd_reg];

  always_comb begin
    push     = in_valid && !full_reg;
    pop      = out_ready && !empty_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    cnt_next   = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    full_next  = (cnt_next == (AW + 1)'(DEPTH));
    room_next  = !full_next;
    empty_next = (cnt_next == '0);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      cnt_reg   <= '0;
      full_reg  <= 1'b0;
      room_reg  <= 1'b1;
      empty_reg <= 1'b1;
    end else begin
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      cnt_reg   <= cnt_next;
      full_reg  <= full_next;
      room_reg  <= room_next;
      empty_reg <= empty_next;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

endmodule

//--- testbench/atpf_link_model.sv
/*
  Behavioural transmit queue of the link: takes framed quadlets and
  counts whole packets.
  Assumes the tq_valid and tq_ready handshake on the rising clk edge.
*/
`timescale 1ns/1ps

module atpf_link_model #(
  parameter int SEED = 1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tq_valid,
  input  wire logic tq_last,
  input  wire logic stall_en,
  output logic      tq_ready,
  output int        pkt_cnt
);
  int seed = SEED;

  // ********
  // Acceptance, stalling at random when asked
  // ********
  initial begin
    tq_ready = 1'h0;
    pkt_cnt = 0;
    forever begin
      @(posedge clk);
      if (!rst && tq_valid && tq_ready) begin
        if (tq_last) begin
          pkt_cnt++;
        end
      end
      #1;
      tq_ready = !rst && !(stall_en && ($random(seed) % 3 == 0));
    end
  end
endmodule

//--- testbench/atpf_host_tb_top.sv
/*
  Self-checking bench of the host framer: builds requests, loads
  payload and checks every quadlet that the link model takes.
  Assumes the design package and constants on the include path.
*/
`timescale 1ns/1ps
`include "atpf_consts.svh"

module atpf_host_tb_top import atpf_pkg::*;;
  logic        clk;
  logic        rst;
  atpf_req_s   cmd_req;
  logic        cmd_valid, cmd_ready, cmd_err;
  logic [31:0] pay_data, tq_data;
  logic        pay_valid, pay_ready, tq_valid, tq_last, tq_ready;
  logic        stall_en;
  int          pkt_cnt;
  int          exp_pkts = 0;
  int          seed = 58782;
  int          error_cnt = 0;
  int          compares = 0;
  logic [32:0] exp_q[$];
  logic [31:0] pay_q[$];
  logic [3:0]  rc_tab[5] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7};

  atpf_host #(.DEPTH(32)) u_dut (
    .clk(clk), .rst(rst), .cmd_req(cmd_req), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_err(cmd_err), .pay_data(pay_data),
    .pay_valid(pay_valid), .pay_ready(pay_ready), .tq_data(tq_data),
    .tq_valid(tq_valid), .tq_last(tq_last), .tq_ready(tq_ready));

  atpf_link_model #(.SEED(4242)) u_link (
    .clk(clk), .rst(rst), .tq_valid(tq_valid), .tq_last(tq_last),
    .stall_en(stall_en), .tq_ready(tq_ready), .pkt_cnt(pkt_cnt));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // ********
  // Compare, handshake and closing tasks
  // ********
  task automatic check_word(input logic [32:0] exp, input logic [32:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t quadlet got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic exp, input logic got, string nm);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %b exp %b", $time, nm, got, exp);
    end
  endtask

  task automatic check_count(input int exp, input int got, string nm);
    compares++;
    if (got != exp) begin
      error_cnt++;
      $display("BAD %0t %s got %0d exp %0d", $time, nm, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wait_hi(ref logic sig);
    int n;
    n = 0;
    @(posedge clk);
    while (sig !== 1'h1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      $display("BAD %0t handshake never came", $time);
    end
    #1;
  endtask

  task automatic load_pay(input int n);
    if (n == 0)
      return;
    pay_valid = 1'h1;
    for (int k = 0; k < n; k++) begin
      pay_data = $random(seed);
      wait_hi(pay_ready);
      pay_q.push_back(pay_data);
    end
    pay_valid = 1'h0;
  endtask

  // ********
  // Request building and sending with expected quadlets
  // ********
  function automatic atpf_req_s mk_req(atpf_kind_e k, int i, int nb);
    atpf_req_s r;
    r.kind = k;
    r.spd = 2'(i % 3);
    r.tag = 6'($random(seed));
    r.retry = 2'((i / 2) % 4);
    r.node_id = 16'($random(seed));
    r.offset_high = 16'($random(seed));
    r.offset_low = {30'($random(seed)), 2'h0};
    r.response_code = rc_tab[i % 5];
    r.payload_byte_count = 16'(nb);
    r.extended_transaction_code = 16'($random(seed));
    return r;
  endfunction

  task automatic send(input atpf_req_s r, input logic err_exp);
    int nw;
    logic resp;
    logic [3:0] tc;
    resp = (r.kind == KIND_WR_RESP) || (r.kind == KIND_RD_RESP);
    nw = 0;
    if (r.kind == KIND_WR_REQ || r.kind == KIND_RD_RESP)
      nw = (r.payload_byte_count + 3) / 4;
    case (r.kind)
      KIND_WR_REQ:  tc = `ATPF_TC_WR_REQ;
      KIND_WR_RESP: tc = `ATPF_TC_WR_RESP;
      KIND_RD_REQ:  tc = `ATPF_TC_RD_REQ;
      default:      tc = `ATPF_TC_RD_RESP;
    endcase
    if (!err_exp) begin
      exp_q.push_back({1'h0, 14'h0, r.spd, r.tag, r.retry, tc, 4'h0});
      if (resp) begin
        exp_q.push_back({1'h0, r.node_id, r.response_code, 12'h0});
        exp_q.push_back({1'h0, 32'h0});
      end else begin
        exp_q.push_back({1'h0, r.node_id, r.offset_high});
        exp_q.push_back({1'h0, r.offset_low});
      end
      exp_q.push_back({nw == 0, r.payload_byte_count,
                       r.extended_transaction_code});
      for (int k = 0; k < nw; k++)
        exp_q.push_back({k == nw - 1, pay_q.pop_front()});
      exp_pkts++;
    end
    cmd_req = r;
    cmd_valid = 1'h1;
    wait_hi(cmd_ready);
    cmd_valid = 1'h0;
    check_flag(err_exp, cmd_err, "cmd_err");
    if (err_exp) begin
      @(posedge clk);
      #1;
      check_flag(1'h0, cmd_err, "cmd_err pulse");
    end else begin
      wait_hi(cmd_ready);
    end
  endtask

  always @(posedge clk) begin
    if (!rst && tq_valid === 1'h1 && tq_ready === 1'h1) begin
      if (exp_q.size() == 0)
        check_count(0, 1, "unexpected quadlet");
      else
        check_word(exp_q.pop_front(),
                   {tq_last, tq_data});
    end
  end

  // ********
  // Main sequence and watchdog
  // ********
  initial begin
    atpf_req_s r;
    rst = 1'h1;
    cmd_valid = 1'h0;
    cmd_req = '0;
    pay_valid = 1'h0;
    pay_data = 32'h0;
    stall_en = 1'h0;
    repeat (12) @(posedge clk);
    check_flag(1'h1, cmd_ready, "reset cmd_ready");
    check_flag(1'h0, tq_valid, "reset tq_valid");
    check_flag(1'h1, pay_ready, "reset pay_ready");
    #1 rst = 1'h0;
    for (int i = 0; i < 12; i++) begin
      stall_en = (i >= 6);
      r = mk_req(atpf_kind_e'(i % 4), i, (i * 9) % 37);
      if (r.kind == KIND_WR_REQ || r.kind == KIND_RD_RESP)
        load_pay((r.payload_byte_count + 3) / 4);
      send(r, 1'h0);
    end
    for (int j = 0; j < 8; j++) begin
      r = mk_req(KIND_RD_RESP, 0, 4);
      if (j == 0)
        r.spd = 2'h3;
      if (j > 0 && j < 6)
        r.response_code = 4'(j < 4 ? j : j * 3);
      if (j >= 6) begin
        r.kind = (j == 6) ? KIND_RD_REQ : KIND_WR_REQ;
        r.offset_low[1:0] = 2'(j - 5);
      end
      send(r, 1'h1);
    end
    stall_en = 1'h1;
    load_pay(32);
    @(posedge clk);
    #1;
    check_flag(1'h0, pay_ready, "pay_ready full");
    pay_valid = 1'h1;
    pay_data = 32'hDEAD_BEEF;
    repeat (2) @(posedge clk);
    #1 pay_valid = 1'h0;
    send(mk_req(KIND_WR_REQ, 4, 128), 1'h0);
    check_flag(1'h1, pay_ready, "pay_ready drained");
    repeat (4) @(posedge clk);
    check_count(exp_pkts, pkt_cnt, "packets");
    check_count(0, exp_q.size(), "missing quadlets");
    report_and_stop();
  end

  initial begin
    #(30000 * 8);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
